// ---- hw/asp_map.svh ----
// Register offsets, field positions, reset values and counts for the serial port.
// Assumes 32-bit classic Wishbone with word-aligned byte addresses.
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH
`define ASP_OFF_DATA      6'h00
`define ASP_OFF_CTRL      6'h04
`define ASP_OFF_TIMER     6'h08
`define ASP_OFF_STATUS    6'h0c
`define ASP_CTRL_RI       0
`define ASP_CTRL_TI       1
`define ASP_CTRL_RB8      2
`define ASP_CTRL_TB8      3
`define ASP_CTRL_REN      4
`define ASP_CTRL_MCE      5
`define ASP_CTRL_RSV      6
`define ASP_CTRL_MODE     7
`define ASP_CTRL_RESET    8'h40
`define ASP_TMR_RELOAD_LO 0
`define ASP_TMR_SRC_LO    8
`define ASP_TMR_RUN       11
`define ASP_TMR_RESET     12'h000
`define ASP_HALF_BITS     5'd22
`define ASP_RX_STOP8      5'd18
`define ASP_RX_STOP9      5'd20
`endif

// ---- hw/asp_pkg.sv ----
// Types shared by the serial port design.
// Assumes asp_map.svh holds all numeric constants.
package asp_pkg;
  typedef enum logic [2:0] {
    ASP_CLK_SYS    = 3'h0,
    ASP_CLK_DIV4   = 3'h1,
    ASP_CLK_DIV12  = 3'h2,
    ASP_CLK_DIV48  = 3'h3,
    ASP_CLK_EXT8   = 3'h4,
    ASP_CLK_TIMIN  = 3'h5
  } asp_clk_src_t;
  typedef enum logic [2:0] {
    ASP_RX_IDLE  = 3'b001,
    ASP_RX_SHIFT = 3'b010,
    ASP_RX_DONE  = 3'b100
  } asp_rx_state_t;
endpackage

// ---- hw/asp_serial_port.sv ----
// Full-duplex asynchronous serial port with timer-derived baud clocks.
// Assumes a 40 MHz core clock, synchronous serial and clock-source inputs.
// Behaviour
// - 8-bit frame: start, 8 LSB-first, stop
// - 9-bit frame adds software ninth bit
// - Data writes load transmit, reads return receive
// - Data write starts a transmit frame
// - Transmit flag set at stop-bit start
// - Receiver starts a frame only with receive enable
// - 8-bit accept: flag clear, filter needs stop
// - Rejected frame leaves buffer and flags
// - Overrun keeps first byte, drops later
// - 9-bit accept: flag clear, filter needs ninth
// - 9-bit receive ignores stop bit level
// - Interrupt request when either flag set
// - Flags cleared only by software
// - Second frame shifts while byte unread
// - Transmit and hidden receive timers
// - Overflows halved to form bit rate
// - Receive timer shares run and reload
// - Start edge reloads receive timer
// - Six selectable timer clock sources
// - One bit selects frame format
// - Mode bit zero 8-bit, one 9-bit
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "asp_map.svh"
module asp_serial_port (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [5:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        ext_osc_in,
  input  wire logic        external_timer_input_in,
  input  wire logic        rx_in,
  output logic             tx_out,
  output logic             serial_irq_out,
  input  wire logic        serial_irq_en_in
);
  import asp_pkg::*;

  // Bus decode
  logic        ack_r;
  logic        req;
  logic        wr;
  logic        wr_data;
  logic        wr_ctrl;
  logic        wr_timer;
  logic        lane0;
  logic        lane1;
  logic        hit;
  assign req      = wb_cyc_in & wb_stb_in & ~ack_r;
  assign wr       = req & wb_we_in;
  assign lane0    = wb_sel_in[0];
  assign lane1    = wb_sel_in[1];
  assign wr_data  = wr & lane0 & (wb_adr_in == `ASP_OFF_DATA);
  assign wr_ctrl  = wr & lane0 & (wb_adr_in == `ASP_OFF_CTRL);
  assign wr_timer = wr & (wb_adr_in == `ASP_OFF_TIMER);
  assign hit      = (wb_adr_in == `ASP_OFF_DATA) | (wb_adr_in == `ASP_OFF_CTRL) |
                    (wb_adr_in == `ASP_OFF_TIMER) | (wb_adr_in == `ASP_OFF_STATUS);

  // Control and timer register fields
  logic [7:0]  ctrl_r;
  logic [11:0] timer_cfg_r;
  logic [7:0]  rx_buf_r;
  logic        mode9;
  logic        multiprocessor_filter_enable;
  logic        ren;
  logic        t1_run;
  logic [7:0]  t1_reload;
  logic [2:0]  src_sel;
  assign mode9     = ctrl_r[`ASP_CTRL_MODE];
  assign multiprocessor_filter_enable       = ctrl_r[`ASP_CTRL_MCE];
  assign ren       = ctrl_r[`ASP_CTRL_REN];
  assign t1_run    = timer_cfg_r[`ASP_TMR_RUN];
  assign t1_reload = timer_cfg_r[`ASP_TMR_RELOAD_LO +: 8];
  assign src_sel   = timer_cfg_r[`ASP_TMR_SRC_LO +: 3];

  // Timer clock prescaler and source select
  logic [5:0]  pre_r;
  logic [2:0]  ext_div_r;
  logic        ext_d_r;
  logic        tin_d_r;
  logic        ext_rise;
  logic        tin_fall;
  logic        tick;
  assign ext_rise = ext_osc_in & ~ext_d_r;
  assign tin_fall = ~external_timer_input_in & tin_d_r;
  always_comb begin
    case (asp_clk_src_t'(src_sel))
      ASP_CLK_SYS:   tick = 1'b1;
      ASP_CLK_DIV4:  tick = (pre_r[1:0] == 2'h3);
      ASP_CLK_DIV12: tick = (pre_r % 6'd12 == 6'd11);
      ASP_CLK_DIV48: tick = (pre_r == 6'd47);
      ASP_CLK_EXT8:  tick = ext_rise & (ext_div_r == 3'h7);
      ASP_CLK_TIMIN: tick = tin_fall;
      default:       tick = 1'b0;
    endcase
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pre_r     <= 6'h00;
      ext_div_r <= 3'h0;
      ext_d_r   <= 1'b0;
      tin_d_r   <= 1'b1;
    end else begin
      pre_r     <= (pre_r == 6'd47) ? 6'h00 : pre_r + 6'h01;
      ext_div_r <= ext_rise ? ext_div_r + 3'h1 : ext_div_r;
      ext_d_r   <= ext_osc_in;
      tin_d_r   <= external_timer_input_in;
    end
  end

  // Transmit timer and hidden receive timer
  logic [7:0]  tx_tmr_r;
  logic [7:0]  rx_tmr_r;
  logic        tx_ovf;
  logic        rx_ovf;
  logic        rx_restart;
  logic        tx_half_r;
  logic        tx_baud;
  assign tx_ovf  = t1_run & tick & (tx_tmr_r == 8'hff);
  assign rx_ovf  = t1_run & tick & (rx_tmr_r == 8'hff);
  assign tx_baud = tx_ovf & tx_half_r;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      tx_tmr_r  <= 8'h00;
      rx_tmr_r  <= 8'h00;
      tx_half_r <= 1'b0;
    end else begin
      if (t1_run & tick)
        tx_tmr_r <= tx_ovf ? t1_reload : tx_tmr_r + 8'h01;
      if (rx_restart)
        rx_tmr_r <= t1_reload;
      else if (t1_run & tick)
        rx_tmr_r <= rx_ovf ? t1_reload : rx_tmr_r + 8'h01;
      if (tx_ovf)
        tx_half_r <= ~tx_half_r;
    end
  end

  // Transmitter
  logic [10:0] tx_shift_r;
  logic [3:0]  tx_cnt_r;
  logic        tx_busy_r;
  logic        tx_line_r;
  logic        tx_stop_begin;
  logic [3:0]  tx_len;
  assign tx_len        = mode9 ? 4'd11 : 4'd10;
  assign tx_stop_begin = tx_busy_r & tx_baud & (tx_cnt_r == tx_len - 4'd1);
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      tx_shift_r <= 11'h7ff;
      tx_cnt_r   <= 4'h0;
      tx_busy_r  <= 1'b0;
      tx_line_r  <= 1'b1;
    end else if (wr_data) begin
      tx_shift_r <= {1'b1, mode9 ? ctrl_r[`ASP_CTRL_TB8] : 1'b1, wb_dat_in[7:0], 1'b0};
      tx_cnt_r   <= 4'h0;
      tx_busy_r  <= 1'b1;
    end else if (tx_busy_r & tx_baud) begin
      tx_line_r  <= tx_shift_r[0];
      tx_shift_r <= {1'b1, tx_shift_r[10:1]};
      tx_cnt_r   <= tx_cnt_r + 4'h1;
      tx_busy_r  <= (tx_cnt_r != tx_len - 4'h1);
    end
  end
  assign tx_out = tx_line_r;

  // Receiver
  asp_rx_state_t rx_state_r;
  logic        rx_d_r;
  logic [4:0]  rx_half_r;
  logic [8:0]  rx_shift_r;
  logic        rx_stop_r;
  logic        rx_start;
  logic        rx_sample;
  logic [4:0]  rx_last;
  logic        rx_ninth;
  logic        rx_accept;
  logic        rx_rb8;
  assign rx_start   = (rx_state_r == ASP_RX_IDLE) & ren & rx_d_r & ~rx_in;
  assign rx_restart = rx_start;
  assign rx_sample  = rx_ovf & ~rx_half_r[0];
  assign rx_last    = mode9 ? `ASP_RX_STOP9 : `ASP_RX_STOP8;
  assign rx_ninth   = mode9 ? rx_shift_r[8] : rx_stop_r;
  assign rx_rb8     = mode9 ? rx_shift_r[8] : rx_stop_r;
  assign rx_accept  = (rx_state_r == ASP_RX_DONE) & ~ctrl_r[`ASP_CTRL_RI] &
                      (~multiprocessor_filter_enable | rx_ninth);
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rx_state_r <= ASP_RX_IDLE;
      rx_d_r     <= 1'b1;
      rx_half_r  <= 5'h00;
      rx_shift_r <= 9'h000;
      rx_stop_r  <= 1'b1;
    end else begin
      rx_d_r <= rx_in;
      case (rx_state_r)
        ASP_RX_IDLE: begin
          rx_half_r <= 5'h00;
          if (rx_start)
            rx_state_r <= ASP_RX_SHIFT;
        end
        ASP_RX_SHIFT: begin
          if (rx_ovf) begin
            rx_half_r <= rx_half_r + 5'h01;
            if (rx_sample & (rx_half_r == 5'h00) & rx_in)
              rx_state_r <= ASP_RX_IDLE;
            else if (rx_sample & (rx_half_r == rx_last))
              rx_state_r <= ASP_RX_DONE;
            if (rx_sample & (rx_half_r != 5'h00) & (rx_half_r != rx_last))
              rx_shift_r <= mode9 ? {rx_in, rx_shift_r[8:1]} : {1'b0, rx_in, rx_shift_r[7:1]};
            if (rx_sample & (rx_half_r == rx_last))
              rx_stop_r <= rx_in;
          end
        end
        ASP_RX_DONE: rx_state_r <= ASP_RX_IDLE;
        default:     rx_state_r <= ASP_RX_IDLE;
      endcase
    end
  end

  // Receive buffer, control register and timer register
  logic [7:0] ctrl_nxt;
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl)
      ctrl_nxt = {wb_dat_in[7], 1'b1, wb_dat_in[5:0]};
    if (tx_stop_begin)
      ctrl_nxt[`ASP_CTRL_TI] = 1'b1;
    if (rx_accept) begin
      ctrl_nxt[`ASP_CTRL_RI]  = 1'b1;
      ctrl_nxt[`ASP_CTRL_RB8] = rx_rb8;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ctrl_r      <= `ASP_CTRL_RESET;
      timer_cfg_r <= `ASP_TMR_RESET;
      rx_buf_r    <= 8'h00;
    end else begin
      ctrl_r <= ctrl_nxt;
      if (wr_timer & lane0)
        timer_cfg_r[7:0] <= wb_dat_in[7:0];
      if (wr_timer & lane1)
        timer_cfg_r[11:8] <= wb_dat_in[11:8];
      if (rx_accept)
        rx_buf_r <= rx_shift_r[7:0];
    end
  end

  // Read data and acknowledge
  logic [31:0] rd_mux;
  assign rd_mux = (wb_adr_in == `ASP_OFF_DATA)   ? {24'h000000, rx_buf_r} :
                  (wb_adr_in == `ASP_OFF_CTRL)   ? {24'h000000, ctrl_r} :
                  (wb_adr_in == `ASP_OFF_TIMER)  ? {20'h00000, timer_cfg_r} :
                  (wb_adr_in == `ASP_OFF_STATUS) ? {27'h0000000, rx_state_r, tx_busy_r,
                                                    rx_d_r} : 32'h00000000;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ack_r      <= 1'b0;
      wb_dat_out <= 32'h00000000;
    end else begin
      ack_r      <= req;
      wb_dat_out <= (req & hit) ? rd_mux : 32'h00000000;
    end
  end
  assign wb_ack_out = ack_r;

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in)
      serial_irq_out <= 1'b0;
    else
      serial_irq_out <= serial_irq_en_in &
                        (ctrl_r[`ASP_CTRL_TI] | ctrl_r[`ASP_CTRL_RI]);
  end
endmodule

// ---- sim/asp_serial_port_checker.sv ----
// Checker on the serial port pins and bus.
// Assumes it is bound into asp_serial_port.
`timescale 1ns/1ps
module asp_checker (
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [5:0]  wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        tx_out,
  input wire logic        serial_irq_out,
  input wire logic        serial_irq_en_in
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire rq = wb_cyc_in && wb_stb_in && !wb_ack_out;
  a_ack_follows: assert property (rq |=> wb_ack_out)
    else $error("no ack");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("long ack");
  a_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("stray ack");
  a_unmapped_zero: assert property (rq && !wb_we_in && wb_adr_in >= 6'h10
    |=> wb_dat_out == 32'h0) else $error("unmapped data");
  a_reserved_one: assert property (rq && !wb_we_in && wb_adr_in == 6'h04
    |=> wb_dat_out[6]) else $error("reserved bit low");
  a_irq_enable: assert property (serial_irq_out |-> $past(serial_irq_en_in))
    else $error("irq while disabled");
  a_flags_sticky: assert property (serial_irq_out && serial_irq_en_in && !wb_cyc_in
    |=> serial_irq_out) else $error("flag cleared by hardware");
  a_reset_idle: assert property ($rose(rst_n_in)
    |-> tx_out && !wb_ack_out && !serial_irq_out) else $error("not idle after reset");
endmodule
bind asp_serial_port asp_checker u_checker (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .tx_out(tx_out),
  .serial_irq_out(serial_irq_out), .serial_irq_en_in(serial_irq_en_in));

// ---- sim/asp_peer.sv ----
// Remote serial node: sends frames to the port and decodes its frames.
// Assumes both ends use a bit time of BIT core clock cycles.
`timescale 1ns/1ps
module asp_peer #(parameter int BIT = 32) (
  input  wire logic clk_in,
  input  wire logic tx_in,
  output logic      rx_out
);
  logic [8:0] got;
  int         n_got;
  initial rx_out = 1'b1;
  // Start, data LSB first, optional ninth, stop; line idles high
  task automatic send(input logic [7:0] d, input logic nine, input logic use9, input logic stop);
    logic [10:0] f;
    f = use9 ? {stop, nine, d, 1'b0} : {1'b1, stop, d, 1'b0};
    for (int i = 0; i < (use9 ? 11 : 10); i++) begin
      @(posedge clk_in);
      rx_out <= f[i];
      repeat (BIT - 1) @(posedge clk_in);
    end
    @(posedge clk_in);
    rx_out <= 1'b1;
    repeat (BIT) @(posedge clk_in);
  endtask
  // Samples nine bits at mid-bit after a falling start edge
  always begin
    @(negedge tx_in);
    repeat (BIT / 2) @(posedge clk_in);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge clk_in);
      got[i] = tx_in;
    end
    n_got++;
  end
endmodule

// ---- sim/test_async_serial_port_with_baud_logic.sv ----
// Bench: Wishbone tasks and peer frames, compared with expected values.
// Assumes the peer model and the checker are compiled first.
`timescale 1ns/1ps
module test_async_serial_port_with_baud_logic;
  localparam int BIT = 32;
  logic        clk, rst_n, req, wen, irq_en, ack, tx, rx, irq;
  logic [5:0]  adr;
  logic [31:0] wdat, rdat, q;
  int          fail_count, n_compared, cycles;
  asp_serial_port dut (.core_clk_in(clk), .rst_n_in(rst_n), .wb_cyc_in(req), .wb_stb_in(req),
    .wb_we_in(wen), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .ext_osc_in(1'b0), .external_timer_input_in(1'b1), .rx_in(rx),
    .tx_out(tx), .serial_irq_out(irq), .serial_irq_en_in(irq_en));
  asp_peer #(.BIT(BIT)) peer (.clk_in(clk), .tx_in(tx), .rx_out(rx));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    req  <= 1'b1;
    wen  <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    req <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    req = 1'b0;
    wen = 1'b0;
    irq_en = 1'b1;
    adr = 6'h0;
    wdat = 32'h0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(6'h04, 32'h40);
    rd(6'h10, 32'h0);
    wb(1'b1, 6'h08, 32'h8f0);
    wb(1'b1, 6'h00, 32'ha5);
    wait (peer.n_got == 1);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    chk({23'h0, peer.got}, 32'h1a5);
    repeat (BIT) @(posedge clk);
    rd(6'h04, 32'h42);
    wb(1'b1, 6'h04, 32'hc8);
    wb(1'b1, 6'h00, 32'h3c);
    wait (peer.n_got == 2);
    @(posedge clk);
    chk({23'h0, peer.got}, 32'h13c);
    chk({31'h0, irq}, 32'h0);
    irq_en <= 1'b0;
    repeat (BIT) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(6'h04, 32'hca);
    irq_en <= 1'b1;
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    $display("transmit test done");
    repeat (BIT) @(posedge clk);
    wb(1'b1, 6'h04, 32'h40);
    peer.send(8'h5a, 1'b0, 1'b0, 1'b1);
    rd(6'h04, 32'h40);
    wb(1'b1, 6'h04, 32'h50);
    peer.send(8'h5a, 1'b0, 1'b0, 1'b1);
    rd(6'h04, 32'h55);
    rd(6'h00, 32'h5a);
    peer.send(8'h33, 1'b0, 1'b0, 1'b1);
    rd(6'h00, 32'h5a);
    fork
      peer.send(8'h77, 1'b0, 1'b0, 1'b1);
      begin
        repeat (BIT * 3) @(posedge clk);
        wb(1'b1, 6'h04, 32'h50);
      end
    join
    rd(6'h00, 32'h77);
    wb(1'b1, 6'h04, 32'h74);
    peer.send(8'h11, 1'b0, 1'b0, 1'b0);
    rd(6'h04, 32'h74);
    rd(6'h00, 32'h77);
    $display("8-bit receive test done");
    wb(1'b1, 6'h04, 32'hf4);
    peer.send(8'h22, 1'b0, 1'b1, 1'b1);
    rd(6'h04, 32'hf4);
    peer.send(8'h44, 1'b1, 1'b1, 1'b0);
    rd(6'h04, 32'hf5);
    rd(6'h00, 32'h44);
    wb(1'b1, 6'h04, 32'hd0);
    peer.send(8'h66, 1'b0, 1'b1, 1'b1);
    rd(6'h04, 32'hd1);
    rd(6'h00, 32'h66);
    $display("9-bit receive test done");
    wb(1'b1, 6'h08, 32'h9fc);
    wb(1'b1, 6'h04, 32'h40);
    wb(1'b1, 6'h00, 32'h96);
    wait (peer.n_got == 3);
    @(posedge clk);
    chk({23'h0, peer.got}, 32'h196);
    $display("clock source test done");
    test_done();
  end
endmodule
